// ### rtl/stepper_phase_sequencer.sv
// How it works
// - edge select high: step on rising edges
// - edge select low: step on both edges
// - resolution pins choose step size per edge mode
// - half step: full current, or 100/71 alternating
// - direction low forward, high reverse
// - host keeps direction steady around clock edges
// - host keeps mode pins steady near edges
// - enable low forces all phase drives off
// - enable low freezes state, ignores step and mode inputs
// - power-on or external reset initialises sequencer
// - host limits step clock frequency
// - host keeps minimum step pulse width
// - host keeps single-edge pulses high 1000 cycles, low 1701 or more, or 1000 after a both-edge step left the clock high
// - host steps only on request; the caller stretches spacing to slow down
// - faults latch, phase drives off, reset clears
// - fault flag pulled low while fault latched
// - host waits after reset before stepping
`timescale 1ns/1ps
`default_nettype none
`include "stepper_params.svh"

module stepper_phase_sequencer (
    // clock, reset, clock enable
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    // power-on reset and protection sensors
    input  wire logic       por_i,
    input  wire logic       overcurrent_i,
    input  wire logic       overheat_i,
    // control pins from the host
    stepper_pins_if.dev     pins,
    // phase drives
    output logic            phase_a_o,
    output logic            phase_ab_o,
    output logic            phase_b_o,
    output logic            phase_bb_o,
    // current commands in percent of set current
    output logic [6:0]      current_a_o,
    output logic [6:0]      current_b_o,
    // monitor and fault level
    output logic            phase_monitor_out_o,
    output logic [1:0]      fault_kind_level_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // mode pins to step resolution
    function automatic stepper_pkg::step_mode_t decode_mode(input logic       edge_sel,
                                                            input logic [1:0] res);
        stepper_pkg::step_mode_t m;
        case ({edge_sel, res})
            3'b100:  m = stepper_pkg::MODE_FULL;
            3'b101:  m = stepper_pkg::MODE_HALF_FULL;
            3'b110:  m = stepper_pkg::MODE_QUARTER;
            3'b111:  m = stepper_pkg::MODE_EIGHTH;
            3'b000:  m = stepper_pkg::MODE_HALF_PSEUDO;
            3'b001:  m = stepper_pkg::MODE_QUARTER;
            3'b010:  m = stepper_pkg::MODE_EIGHTH;
            default: m = stepper_pkg::MODE_SIXTEENTH;
        endcase
        return m;
    endfunction

    // sixteenth steps moved per edge
    function automatic logic [5:0] mode_inc(input stepper_pkg::step_mode_t m);
        logic [5:0] inc;
        case (m)
            stepper_pkg::MODE_FULL:        inc = 6'h10;
            stepper_pkg::MODE_HALF_FULL:   inc = 6'h08;
            stepper_pkg::MODE_HALF_PSEUDO: inc = 6'h08;
            stepper_pkg::MODE_QUARTER:     inc = 6'h04;
            stepper_pkg::MODE_EIGHTH:      inc = 6'h02;
            default:                       inc = 6'h01;
        endcase
        return inc;
    endfunction

    // next grid point of the mode, snapping from any position
    function automatic logic [5:0] step_pos(input logic [5:0] pos,
                                            input logic [5:0] inc,
                                            input logic [5:0] off,
                                            input logic       rev);
        logic [5:0] t;
        logic [5:0] m;
        t = pos - off;
        m = ~(inc - 6'h01);
        if (rev) begin
            t = ((t + inc - 6'h01) & m) - inc;
        end else begin
            t = (t + inc) & m;
        end
        return t + off;
    endfunction

    // current ratio for an angle of idx sixteenths of a quarter turn
    function automatic logic [6:0] amp(input logic [4:0] idx);
        logic [6:0] tbl [0:15];
        tbl = '{7'h00, 7'h0B, 7'h14, 7'h1E, 7'h28, 7'h2F, 7'h37, 7'h40,
                7'h47, 7'h4D, 7'h53, 7'h57, 7'h5D, 7'h5F, 7'h61, 7'h64};
        return idx[4] ? 7'h64 : tbl[idx[3:0]];
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [`PIN_W-1:0] raw;
    logic [`PIN_W-1:0] sync1;
    logic [`PIN_W-1:0] sync2;
    logic [`PIN_W-1:0] sync3;
    logic [`PIN_W-1:0] filt;
    logic [`PIN_W-1:0] next_filt;
    logic [`PIN_W-1:0] upd;

    assign raw = {overheat_i, overcurrent_i, pins.reset_n_in, pins.drive_enable,
                  pins.edge_select_bit, pins.resolution_bit1, pins.resolution_bit0,
                  pins.direction_in, pins.step_clk};

    // accept a change once stages two and three agree; hold step and mode inputs while disabled
    always_comb begin
        upd       = filt[`PIN_EN] ? {`PIN_W{1'b1}} : `PIN_KEEP_MASK;
        next_filt = (upd & ~(sync2 ^ sync3) & sync3) | (~(upd & ~(sync2 ^ sync3)) & filt);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync1 <= `PIN_RESET_VAL;
            sync2 <= `PIN_RESET_VAL;
            sync3 <= `PIN_RESET_VAL;
            filt  <= `PIN_RESET_VAL;
        end else if (ce_i) begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    // ------------------------------------------------------------------
    // reset, edge detection, mode
    // ------------------------------------------------------------------
    logic                    sys_rst;
    logic                    clk_prev;
    logic [1:0]              en_hist;
    logic                    step;
    logic                    fault_any;
    logic                    drive_on;
    stepper_pkg::step_mode_t mode;

    assign sys_rst   = reset_i | por_i | ~filt[`PIN_RSTN];
    assign mode      = decode_mode(filt[`PIN_EDGE], {filt[`PIN_RES1], filt[`PIN_RES0]});
    assign drive_on  = filt[`PIN_EN] & ~fault_any;

    // rising edge always; falling edge only in both-edge mode
    always_comb begin
        step = filt[`PIN_EN] & (&en_hist) &
               ((filt[`PIN_CLK] & ~clk_prev) |
                (~filt[`PIN_CLK] & clk_prev & ~filt[`PIN_EDGE]));
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst) begin
            clk_prev <= 1'b0;
            en_hist  <= 2'b00;
        end else if (ce_i) begin
            clk_prev <= filt[`PIN_CLK];
            en_hist  <= {en_hist[0], filt[`PIN_EN]};
        end
    end

    // ------------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------------
    logic [5:0] pos;
    logic [5:0] next_pos;

    // grid changes with mode but position is kept
    always_comb begin
        next_pos = pos;
        if (step) begin
            next_pos = step_pos(pos, mode_inc(mode),
                                (mode == stepper_pkg::MODE_FULL) ? `FULL_OFFSET
                                                                  : `ZERO_OFFSET,
                                filt[`PIN_DIR]);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst) begin
            pos <= `POS_INIT;
        end else if (ce_i) begin
            pos <= next_pos;
        end
    end

    // ------------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------------
    logic [1:0] fault_q;
    logic [1:0] next_fault;

    // a fault arriving during a clear still latches
    always_comb begin
        next_fault = ((por_i | ~filt[`PIN_RSTN]) ? 2'b00 : fault_q) |
                     {filt[`PIN_OH], filt[`PIN_OC]};
    end

    assign fault_any = |fault_q;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            fault_q <= 2'b00;
        end else if (ce_i) begin
            fault_q <= next_fault;
        end
    end

    // ------------------------------------------------------------------
    // drive outputs
    // ------------------------------------------------------------------
    logic [4:0] ang;
    logic [4:0] ang_c;
    logic [6:0] lvl_a;
    logic [6:0] lvl_b;
    logic       a_neg;
    logic       b_neg;
    logic       full_cur;

    // quadrant picks polarity, angle picks ratio
    always_comb begin
        ang      = {1'b0, pos[3:0]};
        ang_c    = 5'h10 - ang;
        a_neg    = pos[5] ^ pos[4];
        b_neg    = pos[5];
        full_cur = (mode == stepper_pkg::MODE_FULL) ||
                   (mode == stepper_pkg::MODE_HALF_FULL);
        lvl_a    = pos[4] ? amp(ang) : amp(ang_c);
        lvl_b    = pos[4] ? amp(ang_c) : amp(ang);
        lvl_a    = (full_cur && lvl_a != `CUR_ZERO) ? `CUR_FULL : lvl_a;
        lvl_b    = (full_cur && lvl_b != `CUR_ZERO) ? `CUR_FULL : lvl_b;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst) begin
            phase_a_o           <= 1'b0;
            phase_ab_o          <= 1'b0;
            phase_b_o           <= 1'b0;
            phase_bb_o          <= 1'b0;
            current_a_o         <= `CUR_FULL;
            current_b_o         <= `CUR_ZERO;
            phase_monitor_out_o <= 1'b1;
        end else if (ce_i) begin
            phase_a_o           <= drive_on & ~a_neg & (lvl_a != `CUR_ZERO);
            phase_ab_o          <= drive_on & a_neg & (lvl_a != `CUR_ZERO);
            phase_b_o           <= drive_on & ~b_neg & (lvl_b != `CUR_ZERO);
            phase_bb_o          <= drive_on & b_neg & (lvl_b != `CUR_ZERO);
            current_a_o         <= lvl_a;
            current_b_o         <= lvl_b;
            phase_monitor_out_o <= (pos == `POS_INIT);
        end
    end

    // fault outputs straight from the latch
    assign fault_kind_level_o = fault_q;
    assign pins.fault_n_out   = 1'b0;
    assign pins.fault_n_oe_n  = ~fault_any;

endmodule

`default_nettype wire

// ### rtl/stepper_params.svh
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10

// ----------------------------------------------------------------------
// device pin vector layout and reset value
// ----------------------------------------------------------------------
`define PIN_W            9
`define PIN_CLK          0
`define PIN_DIR          1
`define PIN_RES0         2
`define PIN_RES1         3
`define PIN_EDGE         4
`define PIN_EN           5
`define PIN_RSTN         6
`define PIN_OC           7
`define PIN_OH           8
`define PIN_RESET_VAL    9'h040
`define PIN_KEEP_MASK    9'h1E0

// ----------------------------------------------------------------------
// sequencer positions and current levels
// ----------------------------------------------------------------------
`define POS_INIT         6'h00
`define FULL_OFFSET      6'h08
`define ZERO_OFFSET      6'h00
`define CUR_FULL         7'h64
`define CUR_ZERO         7'h00

// ----------------------------------------------------------------------
// host timing, times in ns, counts rounded up to whole cycles
// ----------------------------------------------------------------------
`define SETUP_NS         7000
`define HALF_SINGLE_NS   10000
`define HALF_BOTH_NS     25000
`define RST_LOW_NS       1000
`define RST_REC_NS       10000
`define SETUP_CYC        ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_SINGLE_CYC  ((`HALF_SINGLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_BOTH_CYC    ((`HALF_BOTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LOW_CYC      ((`RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_REC_CYC      ((`RST_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/stepper_pkg.sv
package stepper_pkg;

    // step resolution chosen by the three mode pins
    typedef enum logic [2:0] {
        MODE_FULL        = 3'h0,
        MODE_HALF_FULL   = 3'h1,
        MODE_HALF_PSEUDO = 3'h2,
        MODE_QUARTER     = 3'h3,
        MODE_EIGHTH      = 3'h4,
        MODE_SIXTEENTH   = 3'h5
    } step_mode_t;

    // host pin sequencer states
    typedef enum logic [2:0] {
        H_RESET = 3'b000,
        H_REC   = 3'b001,
        H_IDLE  = 3'b011,
        H_SETUP = 3'b010,
        H_HOLD  = 3'b110
    } host_state_t;

endpackage

// ### rtl/stepper_pins_if.sv
`timescale 1ns/1ps
`default_nettype none

interface stepper_pins_if;
    logic step_clk;
    logic direction_in;
    logic resolution_bit0;
    logic resolution_bit1;
    logic edge_select_bit;
    logic drive_enable;
    logic reset_n_in;
    logic fault_n_out;
    logic fault_n_oe_n;
    logic fault_flag_n;

    // open-drain fault wire with pull-up
    assign fault_flag_n = fault_n_oe_n ? 1'b1 : fault_n_out;

    modport dev (
        input  step_clk,
        input  direction_in,
        input  resolution_bit0,
        input  resolution_bit1,
        input  edge_select_bit,
        input  drive_enable,
        input  reset_n_in,
        output fault_n_out,
        output fault_n_oe_n
    );

    modport host (
        output step_clk,
        output direction_in,
        output resolution_bit0,
        output resolution_bit1,
        output edge_select_bit,
        output drive_enable,
        output reset_n_in,
        input  fault_flag_n
    );
endinterface

`default_nettype wire

// ### rtl/stepper_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "stepper_params.svh"

module stepper_host_ctrl #(
    parameter int CNT_W = 12
) (
    // clock, reset, clock enable
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    // step requests
    input  wire logic       step_req_i,
    input  wire logic       dir_i,
    input  wire logic [1:0] resolution_i,
    input  wire logic       edge_select_i,
    // static controls
    input  wire logic       drive_enable_i,
    input  wire logic       reset_req_i,
    // status
    output logic            busy_o,
    output logic            fault_o,
    // pins to the driver
    stepper_pins_if.host    pins
);

    // counters must hold the longest wait
    if ((1 << CNT_W) <= `HALF_BOTH_CYC) begin : g_cnt_check
        $error("CNT_W too small for host timing counts");
    end

    // ------------------------------------------------------------------
    // pin sequencer
    // ------------------------------------------------------------------
    stepper_pkg::host_state_t state;
    stepper_pkg::host_state_t next_state;
    logic [CNT_W-1:0]         cnt;
    logic [CNT_W-1:0]         next_cnt;
    logic                     clk_q;
    logic                     next_clk;
    logic                     dir_q;
    logic                     next_dir;
    logic [1:0]               res_q;
    logic [1:0]               next_res;
    logic                     es_q;
    logic                     next_es;
    logic                     rstn_q;
    logic                     next_rstn;
    logic [CNT_W-1:0]         half_m1;

    assign half_m1 = es_q ? CNT_W'(`HALF_SINGLE_CYC - 1)
                          : CNT_W'(`HALF_BOTH_CYC - 1);

    // steps come only on request; the caller stretches spacing to slow down
    always_comb begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        next_clk   = clk_q;
        next_dir   = dir_q;
        next_res   = res_q;
        next_es    = es_q;
        next_rstn  = rstn_q;
        case (state)
            stepper_pkg::H_RESET: begin
                if (cnt == '0) begin
                    next_rstn  = 1'b1;
                    next_cnt   = CNT_W'(`RST_REC_CYC - 1);
                    next_state = stepper_pkg::H_REC;
                end
            end
            stepper_pkg::H_REC: begin
                if (cnt == '0) begin
                    next_state = stepper_pkg::H_IDLE;
                end
            end
            stepper_pkg::H_IDLE: begin
                if (reset_req_i) begin
                    next_rstn  = 1'b0;
                    next_cnt   = CNT_W'(`RST_LOW_CYC - 1);
                    next_state = stepper_pkg::H_RESET;
                end else if (step_req_i) begin
                    next_dir   = dir_i;
                    next_res   = resolution_i;
                    next_es    = edge_select_i;
                    next_cnt   = CNT_W'(`SETUP_CYC - 1);
                    next_state = stepper_pkg::H_SETUP;
                end
            end
            stepper_pkg::H_SETUP: begin
                if (cnt == '0) begin
                    if (es_q && clk_q) begin
                        next_clk = 1'b0;  // single edge: low phase first
                        next_cnt = CNT_W'(`HALF_SINGLE_CYC - 1);
                    end else begin
                        next_clk   = ~clk_q;
                        next_cnt   = half_m1;
                        next_state = stepper_pkg::H_HOLD;
                    end
                end
            end
            stepper_pkg::H_HOLD: begin
                if (cnt == '0) begin
                    if (es_q && clk_q) begin
                        next_clk = 1'b0;  // finish the single-edge pulse
                        next_cnt = CNT_W'(`HALF_SINGLE_CYC - 1);
                    end else begin
                        next_state = stepper_pkg::H_IDLE;
                    end
                end
            end
            default: begin
                next_state = stepper_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state  <= stepper_pkg::H_RESET;
            cnt    <= CNT_W'(`RST_LOW_CYC - 1);
            clk_q  <= 1'b0;
            dir_q  <= 1'b0;
            res_q  <= 2'b00;
            es_q   <= 1'b1;
            rstn_q <= 1'b0;
        end else if (ce_i) begin
            state  <= next_state;
            cnt    <= next_cnt;
            clk_q  <= next_clk;
            dir_q  <= next_dir;
            res_q  <= next_res;
            es_q   <= next_es;
            rstn_q <= next_rstn;
        end
    end

    // ------------------------------------------------------------------
    // enable register and fault pin synchroniser
    // ------------------------------------------------------------------
    logic en_q;
    logic f1;
    logic f2;
    logic f3;
    logic next_fault;

    // fault counts once stages two and three agree
    always_comb begin
        next_fault = (f2 == f3) ? ~f3 : fault_o;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            en_q    <= 1'b0;
            f1      <= 1'b1;
            f2      <= 1'b1;
            f3      <= 1'b1;
            fault_o <= 1'b0;
        end else if (ce_i) begin
            en_q    <= drive_enable_i;
            f1      <= pins.fault_flag_n;
            f2      <= f1;
            f3      <= f2;
            fault_o <= next_fault;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    assign busy_o               = (state != stepper_pkg::H_IDLE);
    assign pins.step_clk        = clk_q;
    assign pins.direction_in    = dir_q;
    assign pins.resolution_bit0 = res_q[0];
    assign pins.resolution_bit1 = res_q[1];
    assign pins.edge_select_bit = es_q;
    assign pins.drive_enable    = en_q;
    assign pins.reset_n_in      = rstn_q;

endmodule

`default_nettype wire

// ### bench/stepper_link_sva.sv
`timescale 1ns/1ps
`default_nettype none

module stepper_link_sva (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic por_i,
    // link wires
    input  wire logic step_clk,
    input  wire logic direction_in,
    input  wire logic resolution_bit0,
    input  wire logic resolution_bit1,
    input  wire logic edge_select_bit,
    input  wire logic reset_n_in,
    input  wire logic fault_n_out,
    input  wire logic fault_n_oe_n
);
    // ------------------------------------------------------------
    // ages of clock level, settings and reset pin
    // ------------------------------------------------------------
    localparam int SETUP = 699;
    localparam int HI_1  = 999;
    localparam int HI_2  = 1999;
    logic [11:0] clk_age, cfg_age, rst_age;
    logic [3:0]  cfg_q;
    logic        clk_q;
    logic [3:0]  cfg;

    assign cfg = {direction_in, resolution_bit1, resolution_bit0, edge_select_bit};

    // saturating counters, cleared on change; reset age held at zero while the pin is low
    always_ff @(posedge ref_clk_i) begin
        clk_q   <= step_clk;
        cfg_q   <= cfg;
        clk_age <= (reset_i || clk_q != step_clk) ? 12'h000 : clk_age + {11'h000, ~&clk_age};
        cfg_age <= (reset_i || cfg_q != cfg) ? 12'h000 : cfg_age + {11'h000, ~&cfg_age};
        rst_age <= (reset_i || !reset_n_in) ? 12'h000 : rst_age + {11'h000, ~&rst_age};
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_edge;
        $changed(step_clk);
    endsequence
    sequence s_pin_low;
        !reset_n_in [*8];
    endsequence

    a_cfg_before_edge: assert property (s_edge |-> cfg_age >= SETUP)
        else $error("settings changed too close before a clock edge");
    a_cfg_after_edge: assert property (cfg_q != cfg |-> clk_age >= SETUP)
        else $error("settings changed too close after a clock edge");
    a_pulse_single: assert property (edge_select_bit && $fell(step_clk) |-> clk_age >= HI_1)
        else $error("single edge pulse too short");
    a_pulse_both: assert property ((!edge_select_bit and s_edge) |-> clk_age >= HI_2)
        else $error("both edge half period too short");
    a_reset_wait: assert property (s_edge |-> rst_age >= 1000)
        else $error("clock edge too soon after reset pin release");
    a_reset_pulse: assert property ($fell(reset_n_in) |-> s_pin_low)
        else $error("reset pin pulse too short");
    a_fault_drive: assert property (!fault_n_oe_n |-> !fault_n_out)
        else $error("fault flag enabled but not driven low");
    a_fault_latched: assert property (!fault_n_oe_n && !por_i && rst_age >= 8 |=> !fault_n_oe_n)
        else $error("fault latch released without reset");
endmodule

`default_nettype wire

// ### bench/tb_stepper_phase_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module tb_stepper_phase_sequencer;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       ref_clk_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic       por_i     = 1'b0;
    logic       oc_i      = 1'b0;
    logic       oh_i      = 1'b0;
    logic       step_req  = 1'b0;
    logic       dir       = 1'b0;
    logic [1:0] res       = 2'h0;
    logic       edge_sel  = 1'b1;
    logic       en        = 1'b0;
    logic       rreq      = 1'b0;
    logic       busy, fault_o, pa, pab, pb, pbb, mon;
    logic [6:0] cur_a, cur_b;
    logic [1:0] lvl;
    int         err_count = 0;
    int         total_checks = 0;

    // clock
    initial forever #5 ref_clk_i = ~ref_clk_i;

    // ------------------------------------------------------------
    // the two ends and the checker
    // ------------------------------------------------------------
    stepper_pins_if stepper_pins_if_i ();

    stepper_phase_sequencer stepper_phase_sequencer_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1), .por_i(por_i),
        .overcurrent_i(oc_i), .overheat_i(oh_i), .pins(stepper_pins_if_i),
        .phase_a_o(pa), .phase_ab_o(pab), .phase_b_o(pb), .phase_bb_o(pbb),
        .current_a_o(cur_a), .current_b_o(cur_b), .phase_monitor_out_o(mon),
        .fault_kind_level_o(lvl));

    stepper_host_ctrl stepper_host_ctrl_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1), .step_req_i(step_req),
        .dir_i(dir), .resolution_i(res), .edge_select_i(edge_sel), .drive_enable_i(en),
        .reset_req_i(rreq), .busy_o(busy), .fault_o(fault_o), .pins(stepper_pins_if_i));

    stepper_link_sva stepper_link_sva_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .por_i(por_i),
        .step_clk(stepper_pins_if_i.step_clk), .direction_in(stepper_pins_if_i.direction_in),
        .resolution_bit0(stepper_pins_if_i.resolution_bit0),
        .resolution_bit1(stepper_pins_if_i.resolution_bit1),
        .edge_select_bit(stepper_pins_if_i.edge_select_bit),
        .reset_n_in(stepper_pins_if_i.reset_n_in), .fault_n_out(stepper_pins_if_i.fault_n_out),
        .fault_n_oe_n(stepper_pins_if_i.fault_n_oe_n));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare both current commands
    task automatic cur(input logic [7:0] a, input logic [7:0] b);
        chk({1'b0, cur_a}, a);
        chk({1'b0, cur_b}, b);
    endtask

    // bounded wait for the host to go idle
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 5000) begin
            err_count++;
            conclude();
        end
    endtask

    // one step request, or a host reset when hr is set; then check both currents
    task automatic step(input logic d, input logic [1:0] r, input logic e,
                        input logic [7:0] a, input logic [7:0] b, input logic hr = 1'b0);
        idle();
        step_req <= ~hr;
        rreq     <= hr;
        dir      <= d;
        res      <= r;
        edge_sel <= e;
        @(posedge ref_clk_i);
        step_req <= 1'b0;
        rreq     <= 1'b0;
        @(posedge ref_clk_i);
        idle();
        repeat (400) @(posedge ref_clk_i);
        cur(a, b);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        idle();
        cur(8'h64, 8'h00);
        chk({7'h00, mon}, 8'h01);
        en <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        step(1'b0, 2'h1, 1'b1, 8'h64, 8'h64);
        step(1'b0, 2'h0, 1'b0, 8'h00, 8'h64);
        step(1'b0, 2'h0, 1'b0, 8'h47, 8'h47);
        step(1'b0, 2'h1, 1'b0, 8'h5D, 8'h28);
        step(1'b0, 2'h2, 1'b0, 8'h61, 8'h14);
        step(1'b1, 2'h2, 1'b1, 8'h5D, 8'h28);
        step(1'b1, 2'h3, 1'b1, 8'h53, 8'h37);
        step(1'b1, 2'h3, 1'b0, 8'h4D, 8'h40);
        step(1'b0, 2'h0, 1'b1, 8'h64, 8'h64);
        en <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        chk({4'h0, pa, pab, pb, pbb}, 8'h00);
        step(1'b1, 2'h1, 1'b1, 8'h64, 8'h64);
        en <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        cur(8'h64, 8'h64);
        oc_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        oc_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        chk({6'h00, lvl}, 8'h01);
        chk({7'h00, fault_o}, 8'h01);
        chk({4'h0, pa, pab, pb, pbb}, 8'h00);
        step(1'b0, 2'h1, 1'b1, 8'h64, 8'h00, 1'b1);
        chk({6'h00, lvl}, 8'h00);
        chk({7'h00, fault_o}, 8'h00);
        oh_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        oh_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        chk({6'h00, lvl}, 8'h02);
        por_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        por_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        chk({6'h00, lvl}, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
